// ===== dtml_ctrl_model.sv
// behavioural memory controller driving command, termination, strobe and clock level
`timescale 1ns/10ps
module dtml_ctrl_model import dtml_pkg::*; (
    input wire logic clock,
    output dtml_cmd_t cmd,
    output logic odt,
    output logic dqs_pin,
    output logic ck_pin
);
    // deselected and quiet at start; strobe stands low outside pulses
    initial begin
        cmd = {4'b1111, 3'h0, 13'h0000};
        odt = 1'b0;
        dqs_pin = 1'b0;
        ck_pin = 1'b0;
    end
    // one command for one clock, then deselect with the bus inverted
    // so a stale address is never mistaken for a live one
    task automatic issue(input logic [3:0] code, input logic [2:0] b, input logic [12:0] a);
        @(posedge clock);
        cmd <= {code, b, a};
        @(posedge clock);
        cmd <= {4'b1111, ~b, ~a};
    endtask
    // mode command; banks are never opened, so they are always idle
    task automatic mrs(input logic [2:0] b, input logic [12:0] a);
        issue(4'b0000, b, a);
    endtask
    // read with column bits 1:0 forced to zero; lock is assumed from reset
    task automatic rd(input logic [2:0] b, input logic [12:0] a);
        issue(4'b0101, b, a & 13'h1ffc);
    endtask
    // one strobe pulse sampling the given clock level
    task automatic strobe(input logic lvl);
        @(posedge clock);
        ck_pin <= lvl;
        @(posedge clock);
        dqs_pin <= 1'b1;
        repeat (5) @(posedge clock);
        dqs_pin <= 1'b0;
        repeat (5) @(posedge clock);
    endtask
    // termination pin, held at the level given
    task automatic set_odt(input logic v);
        @(posedge clock);
        odt <= v;
    endtask
endmodule

// ===== dtml_pkg.sv
// constants, types and helpers of the training mode logic
// Summary of operation
// - feedback on prime bit or all; others low
// - feedback is clock level at strobe rise
// - data pins undefined until tMOD after exit
// - commands after tMOD, mode commands after tMRD
// - register 3 bit A2 high enters pattern mode
// - pattern mode reads served from pattern register
// - read with auto precharge acts as read
// - reset still works in pattern mode
// - A2 low reads array, location bits ignored
// - lane bit 0 carries pattern, others copy/zero
// - burst chop nibble chosen by read A2
// - bank and upper column bits ignored
// - A12 chops burst on the fly if enabled
// - pattern reads use array read latency
// - location zero returns alternating zero one pattern
// - burst order bit 0 is LSB
// - register 1 bit A7 enters and leaves leveling
// - strobe rise samples clock, drives feedback
// - leveling termination pin switches strobe termination only
package dtml_pkg;
    // bus widths
    localparam int DTML_DQ_W = 16;
    localparam int DTML_LANE_W = 8;
    localparam int DTML_ADDR_W = 13;
    // mode register selects on the bank address pins
    localparam logic [2:0] DTML_BA_MR0 = 3'h0;
    localparam logic [2:0] DTML_BA_MR1 = 3'h1;
    localparam logic [2:0] DTML_BA_MR3 = 3'h3;
    // field positions in the address word
    localparam int DTML_MR0_BL_LSB = 0;
    localparam int DTML_MR1_WL_BIT = 7;
    localparam int DTML_MR1_QOFF_BIT = 12;
    localparam int DTML_MR3_MPR_BIT = 2;
    localparam int DTML_MR3_LOC_LSB = 0;
    localparam int DTML_RD_NIB_BIT = 2;
    localparam int DTML_RD_AP_BIT = 10;
    localparam int DTML_RD_BC_BIT = 12;
    // burst length field encodings
    localparam logic [1:0] DTML_BL_FIX8 = 2'h0;
    localparam logic [1:0] DTML_BL_OTF = 2'h1;
    localparam logic [1:0] DTML_BL_FIX4 = 2'h2;
    // reset values
    localparam logic [1:0] DTML_BL_RST = 2'h0;
    localparam logic [1:0] DTML_LOC_RST = 2'h0;
    localparam logic DTML_WL_RST = 1'b0;
    localparam logic DTML_QOFF_RST = 1'b0;
    localparam logic DTML_MPR_RST = 1'b0;
    // pattern locations; reserved ones return a fixed word
    localparam logic [1:0] DTML_LOC_CAL = 2'h0;
    localparam logic [7:0] DTML_PAT_CAL = 8'haa;
    localparam logic [7:0] DTML_PAT_RFU = 8'h00;
    // timing: tMOD is the larger of 12 clocks and 15 ns, tMRD is 4 clocks
    localparam int DTML_CLK_NS = 50;
    localparam int DTML_TMOD_NCK = 12;
    localparam int DTML_TMOD_NS = 15;
    localparam int DTML_TMOD_NS_CYC = (DTML_TMOD_NS + DTML_CLK_NS - 1) / DTML_CLK_NS;
    localparam int DTML_TMOD_CYC = (DTML_TMOD_NCK > DTML_TMOD_NS_CYC) ?
        DTML_TMOD_NCK : DTML_TMOD_NS_CYC;
    localparam int DTML_TMRD_CYC = 4;
    localparam int DTML_TMR_W = 4;
    // command pins, sampled on the rising clock
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [DTML_ADDR_W-1:0] addr;
    } dtml_cmd_t;
    // one read as handed to the burst engine
    typedef struct packed {
        logic calibration_pattern_register;
        logic bc4;
        logic nib;
        logic [7:0] pat;
    } dtml_rd_t;
    // write leveling sequence
    typedef enum logic [3:0] {
        DTML_WL_IDLE = 4'b0001,
        DTML_WL_ARMED = 4'b0010,
        DTML_WL_FB = 4'b0100,
        DTML_WL_UNDEF = 4'b1000
    } dtml_wl_st_t;
    // one bit onto both lanes: bit 0 always, bits 7..1 copied or zero
    function automatic logic [DTML_DQ_W-1:0] dtml_lane_fill(input logic b, input logic repl);
        logic [DTML_LANE_W-1:0] lane;
        lane = {{(DTML_LANE_W-1){b & repl}}, b};
        return {lane, lane};
    endfunction
endpackage

// ===== dtml_rd_burst.sv
// read latency pipe and burst beat generator
`timescale 1ns/10ps
module dtml_rd_burst import dtml_pkg::*; #(
    parameter int RL = 6,
    parameter logic REPL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic launch,
    input wire dtml_rd_t launch_info,
    input wire logic [DTML_DQ_W-1:0] arr_rdata,
    output logic beat_vld_ff,
    output logic [DTML_DQ_W-1:0] beat_data_ff
);
    localparam int DEPTH = (RL > 1) ? RL - 1 : 1;
    dtml_rd_t pipe_ff [DEPTH]; // read info in flight
    logic [DEPTH-1:0] pvld_ff; // one valid bit per stage
    dtml_rd_t cur_ff; // burst being sent
    logic [2:0] cnt_ff; // next beat index
    logic busy_ff; // burst still running
    logic tap; // read reaches the data phase
    dtml_rd_t sel; // info of the beat being built
    logic [2:0] beat_n; // beat index being built
    logic [2:0] ord; // burst order position
    logic last;

    // array and pattern reads share this one pipe, so latency is identical
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pvld_ff <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                pipe_ff[i] <= '0;
            end
        end else begin
            pvld_ff <= {pvld_ff[DEPTH-2:0], launch};
            pipe_ff[0] <= launch_info;
            for (int i = 1; i < DEPTH; i++) begin
                pipe_ff[i] <= pipe_ff[i-1];
            end
        end
    end

    assign tap = pvld_ff[DEPTH-1];

    // beat selection; a new read restarts the counter for back-to-back bursts
    always_comb begin
        sel = tap ? pipe_ff[DEPTH-1] : cur_ff;
        beat_n = tap ? 3'h0 : cnt_ff;
        // chop picks the nibble from the read address
        ord = sel.bc4 ? {sel.nib, beat_n[1:0]} : beat_n;
        last = sel.bc4 ? (beat_n[1:0] == 2'h3) : (beat_n == 3'h7);
    end

    // burst counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cnt_ff <= 3'h0;
            busy_ff <= 1'b0;
        end else if (tap || busy_ff) begin
            cur_ff <= sel;
            cnt_ff <= beat_n + 3'h1;
            busy_ff <= !last;
        end
    end

    // beat data; order bit 0 is the pattern LSB
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            beat_vld_ff <= 1'b0;
            beat_data_ff <= '0;
        end else begin
            beat_vld_ff <= tap || busy_ff;
            if (sel.calibration_pattern_register) begin
                beat_data_ff <= dtml_lane_fill(sel.pat[ord], REPL);
            end else begin
                beat_data_ff <= arr_rdata; // array read
            end
        end
    end
endmodule

// ===== dtml_train.sv
// training mode logic: write leveling feedback and pattern register reads
`timescale 1ns/10ps
module dtml_train import dtml_pkg::*; #(
    parameter int AL = 0,
    parameter int CL = 6,
    parameter logic PRIME_ONLY = 1'b1,
    parameter logic REPL = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire dtml_cmd_t cmd,
    input wire logic odt,
    input wire logic dqs_pin,
    input wire logic ck_pin,
    input wire logic [DTML_DQ_W-1:0] arr_rdata,
    output logic [DTML_DQ_W-1:0] dq_out_ff,
    output logic dq_oe_n_ff,
    output logic dq_undef_ff,
    output logic dqs_term_on_ff,
    output logic dq_term_on_ff,
    output logic wl_active_ff,
    output logic mpr_active_ff,
    output logic cmd_ready_ff,
    output logic mrs_ready_ff,
    output logic arr_rd_req_ff,
    output logic [2:0] arr_ba_ff,
    output logic [9:0] arr_col_ff,
    output logic auto_pre_req_ff
);
    localparam int RL = AL + CL;
    localparam logic [DTML_TMR_W-1:0] TMOD_LD = DTML_TMR_W'(DTML_TMOD_CYC);
    localparam logic [DTML_TMR_W-1:0] TMRD_LD = DTML_TMR_W'(DTML_TMRD_CYC);

    // mode register copies
    logic [1:0] bl_mode_ff; // burst length field
    logic wl_en_ff; // write leveling enable
    logic qoff_ff; // output buffer off
    logic mpr_en_ff; // pattern register mode
    logic [1:0] loc_ff; // pattern location select
    // after-command timers
    logic [DTML_TMR_W-1:0] tmod_cnt_ff;
    logic [DTML_TMR_W-1:0] tmrd_cnt_ff;
    // pin synchronisers, first stage feeds only the second
    logic [2:0] dqs_sync_ff;
    logic [2:0] ck_sync_ff;
    logic dqs_lvl_ff; // agreed strobe level
    logic ck_lvl_ff; // agreed clock sample level
    // leveling state
    dtml_wl_st_t wl_st_ff;
    dtml_wl_st_t nxt_wl_st;
    logic fb_ff; // latest feedback value
    // decode
    logic is_mrs;
    logic is_rd;
    logic mrs_mr0;
    logic mrs_mr1;
    logic mrs_mr3;
    logic dqs_agree;
    logic ck_agree;
    logic dqs_rise;
    logic ck_now;
    logic rd_launch;
    dtml_rd_t rd_info;
    logic beat_vld;
    logic [DTML_DQ_W-1:0] beat_data;

    // command decode from the four control pins
    function automatic logic dtml_cmd_match(input dtml_cmd_t c, input logic [2:0] rcw);
        return !c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == rcw);
    endfunction

    assign is_mrs = dtml_cmd_match(cmd, 3'h0);
    assign is_rd = dtml_cmd_match(cmd, 3'h5);
    assign mrs_mr0 = is_mrs && (cmd.ba == DTML_BA_MR0);
    assign mrs_mr1 = is_mrs && (cmd.ba == DTML_BA_MR1);
    assign mrs_mr3 = is_mrs && (cmd.ba == DTML_BA_MR3);

    // mode registers; reset is a plain async clear and works in every mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bl_mode_ff <= DTML_BL_RST;
            wl_en_ff <= DTML_WL_RST;
            qoff_ff <= DTML_QOFF_RST;
            mpr_en_ff <= DTML_MPR_RST;
            loc_ff <= DTML_LOC_RST;
        end else begin
            if (mrs_mr0) begin
                bl_mode_ff <= cmd.addr[DTML_MR0_BL_LSB +: 2];
            end
            if (mrs_mr1) begin
                // A7 enters and leaves leveling
                wl_en_ff <= cmd.addr[DTML_MR1_WL_BIT];
                qoff_ff <= cmd.addr[DTML_MR1_QOFF_BIT];
            end
            if (mrs_mr3) begin
                // A2 high enters pattern mode, low returns to array
                mpr_en_ff <= cmd.addr[DTML_MR3_MPR_BIT];
                loc_ff <= cmd.addr[DTML_MR3_LOC_LSB +: 2];
            end
        end
    end

    // tMOD timer: any valid command may follow once it runs out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tmod_cnt_ff <= '0;
            cmd_ready_ff <= 1'b1;
        end else if (is_mrs) begin
            tmod_cnt_ff <= TMOD_LD - DTML_TMR_W'(1);
            cmd_ready_ff <= 1'b0;
        end else if (tmod_cnt_ff != '0) begin
            tmod_cnt_ff <= tmod_cnt_ff - DTML_TMR_W'(1);
        end else begin
            cmd_ready_ff <= 1'b1;
        end
    end

    // tMRD timer: the next mode command is allowed sooner
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tmrd_cnt_ff <= '0;
            mrs_ready_ff <= 1'b1;
        end else if (is_mrs) begin
            tmrd_cnt_ff <= TMRD_LD - DTML_TMR_W'(1);
            mrs_ready_ff <= 1'b0;
        end else if (tmrd_cnt_ff != '0) begin
            tmrd_cnt_ff <= tmrd_cnt_ff - DTML_TMR_W'(1);
        end else begin
            mrs_ready_ff <= 1'b1;
        end
    end

    // strobe and clock-level pins are asynchronous to us: three stages each
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dqs_sync_ff <= 3'h0;
            ck_sync_ff <= 3'h0;
        end else begin
            dqs_sync_ff <= {dqs_sync_ff[1:0], dqs_pin};
            ck_sync_ff <= {ck_sync_ff[1:0], ck_pin};
        end
    end

    // a change counts only once stages two and three agree
    assign dqs_agree = (dqs_sync_ff[1] == dqs_sync_ff[2]);
    assign ck_agree = (ck_sync_ff[1] == ck_sync_ff[2]);
    assign dqs_rise = dqs_agree && dqs_sync_ff[2] && !dqs_lvl_ff;
    assign ck_now = ck_agree ? ck_sync_ff[2] : ck_lvl_ff;

    // agreed levels
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dqs_lvl_ff <= 1'b0;
            ck_lvl_ff <= 1'b0;
        end else begin
            if (dqs_agree) begin
                dqs_lvl_ff <= dqs_sync_ff[2];
            end
            if (ck_agree) begin
                ck_lvl_ff <= ck_sync_ff[2];
            end
        end
    end

    // feedback sample: clock high reads 1, low reads 0
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fb_ff <= 1'b0;
        end else if (dqs_rise && wl_en_ff) begin
            fb_ff <= ck_now;
        end
    end

    // leveling sequence
    always_comb begin
        nxt_wl_st = wl_st_ff;
        case (wl_st_ff)
            DTML_WL_IDLE: begin
                if (mrs_mr1 && cmd.addr[DTML_MR1_WL_BIT]) begin
                    nxt_wl_st = DTML_WL_ARMED;
                end
            end
            DTML_WL_ARMED: begin
                if (mrs_mr1 && !cmd.addr[DTML_MR1_WL_BIT]) begin
                    nxt_wl_st = DTML_WL_UNDEF;
                end else if (dqs_rise) begin
                    nxt_wl_st = DTML_WL_FB; // first sample taken
                end
            end
            DTML_WL_FB: begin
                // exit: pins go undefined until tMOD after the command
                if (mrs_mr1 && !cmd.addr[DTML_MR1_WL_BIT]) begin
                    nxt_wl_st = DTML_WL_UNDEF;
                end
            end
            DTML_WL_UNDEF: begin
                if (mrs_mr1 && cmd.addr[DTML_MR1_WL_BIT]) begin
                    nxt_wl_st = DTML_WL_ARMED;
                end else if (!is_mrs && tmod_cnt_ff == '0) begin
                    nxt_wl_st = DTML_WL_IDLE;
                end
            end
            default: begin
                nxt_wl_st = DTML_WL_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wl_st_ff <= DTML_WL_IDLE;
        end else begin
            wl_st_ff <= nxt_wl_st;
        end
    end

    // read hand-off; leveling blocks reads since only idle commands are legal then
    always_comb begin
        rd_launch = is_rd && !wl_en_ff;
        rd_info.calibration_pattern_register = mpr_en_ff; // pattern mode redirects reads
        // chop by mode register, or on the fly by A12 low
        rd_info.bc4 = (bl_mode_ff == DTML_BL_FIX4) ||
            ((bl_mode_ff == DTML_BL_OTF) && !cmd.addr[DTML_RD_BC_BIT]);
        rd_info.nib = cmd.addr[DTML_RD_NIB_BIT] && rd_info.bc4;
        // location from mode register 3; reserved ones give a fixed word
        rd_info.pat = (loc_ff == DTML_LOC_CAL) ? DTML_PAT_CAL : DTML_PAT_RFU;
    end

    // array access; in pattern mode bank, column and precharge are ignored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arr_rd_req_ff <= 1'b0;
            arr_ba_ff <= 3'h0;
            arr_col_ff <= 10'h000;
            auto_pre_req_ff <= 1'b0;
        end else begin
            // array only when pattern mode is off
            arr_rd_req_ff <= rd_launch && !mpr_en_ff;
            // auto precharge suppressed in pattern mode
            auto_pre_req_ff <= rd_launch && !mpr_en_ff && cmd.addr[DTML_RD_AP_BIT];
            if (rd_launch && !mpr_en_ff) begin
                arr_ba_ff <= cmd.ba;
                arr_col_ff <= cmd.addr[9:0];
            end
        end
    end

    // shared latency pipe and burst generator
    dtml_rd_burst #(
        .RL(RL),
        .REPL(REPL)
    ) u_burst (
        .clock(clock),
        .rst_n(rst_n),
        .launch(rd_launch),
        .launch_info(rd_info),
        .arr_rdata(arr_rdata),
        .beat_vld_ff(beat_vld),
        .beat_data_ff(beat_data)
    );

    // data pins: feedback in leveling, read beats otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_out_ff <= '0;
            dq_oe_n_ff <= 1'b1;
        end else if (wl_st_ff == DTML_WL_FB) begin
            // prime bit only, rest held low, or every bit
            dq_out_ff <= dtml_lane_fill(fb_ff, !PRIME_ONLY);
            dq_oe_n_ff <= qoff_ff; // output buffer off keeps pins released
        end else if (beat_vld) begin
            dq_out_ff <= beat_data;
            dq_oe_n_ff <= 1'b0;
        end else begin
            dq_out_ff <= '0;
            dq_oe_n_ff <= 1'b1;
        end
    end

    // status and termination; leveling lets the pin switch strobe termination only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dq_undef_ff <= 1'b0;
            dqs_term_on_ff <= 1'b0;
            dq_term_on_ff <= 1'b0;
            wl_active_ff <= 1'b0;
            mpr_active_ff <= 1'b0;
        end else begin
            dq_undef_ff <= (nxt_wl_st == DTML_WL_ARMED) || (nxt_wl_st == DTML_WL_UNDEF);
            dqs_term_on_ff <= odt && wl_en_ff;
            dq_term_on_ff <= odt && !wl_en_ff;
            wl_active_ff <= wl_en_ff;
            mpr_active_ff <= mpr_en_ff;
        end
    end
endmodule

// ===== dtml_train_chk_sva.sv
// assertion checker for the training mode logic, bound to its top ports
`timescale 1ns/10ps
module dtml_train_chk import dtml_pkg::*; #(
    parameter logic PRIME_ONLY = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire dtml_cmd_t cmd,
    input wire logic odt,
    input wire logic [DTML_DQ_W-1:0] dq_out_ff,
    input wire logic dq_oe_n_ff,
    input wire logic dq_undef_ff,
    input wire logic dqs_term_on_ff,
    input wire logic dq_term_on_ff,
    input wire logic wl_active_ff,
    input wire logic mpr_active_ff,
    input wire logic cmd_ready_ff,
    input wire logic mrs_ready_ff,
    input wire logic arr_rd_req_ff,
    input wire logic auto_pre_req_ff
);
    // command decode on the sampled pins
    wire logic is_mrs = !cmd.cs_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n;
    wire logic is_rd = !cmd.cs_n && cmd.ras_n && !cmd.cas_n && cmd.we_n;
    wire logic mr1 = is_mrs && cmd.ba == DTML_BA_MR1;
    wire logic mr3 = is_mrs && cmd.ba == DTML_BA_MR3;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // mode copy lands at the command edge, the status flag one edge later
    chk_pattern_mode: assert property (
        mr3 |=> ##1 mpr_active_ff == $past(cmd.addr[2], 2))
        else $error("pattern mode flag wrong");
    chk_level_mode: assert property (
        mr1 |=> ##1 wl_active_ff == $past(cmd.addr[7], 2))
        else $error("leveling flag wrong");
    chk_mrd_gap: assert property (is_mrs |=> !mrs_ready_ff [*4] ##1 mrs_ready_ff)
        else $error("mode command gap wrong");
    chk_mod_gap: assert property (
        is_mrs |=> !cmd_ready_ff [*8] ##1 !cmd_ready_ff [*4] ##1 cmd_ready_ff)
        else $error("command gap wrong");
    chk_pattern_no_array: assert property (
        is_rd && mpr_active_ff |=> !arr_rd_req_ff && !auto_pre_req_ff)
        else $error("array touched in pattern mode");
    chk_array_read: assert property (
        is_rd && !mpr_active_ff && !wl_active_ff
        |=> arr_rd_req_ff && auto_pre_req_ff == $past(cmd.addr[10]))
        else $error("array read not taken");
    chk_read_latency: assert property (
        is_rd && !wl_active_ff |-> ##6 dq_oe_n_ff ##1 !dq_oe_n_ff [*4])
        else $error("read latency wrong");
    chk_prime_fill: assert property (
        wl_active_ff && !dq_oe_n_ff && PRIME_ONLY
        |-> dq_out_ff[15:9] == 7'h00 && dq_out_ff[7:1] == 7'h00)
        else $error("non prime bits not low");
    chk_lane_copy: assert property (
        mpr_active_ff && !dq_oe_n_ff |-> dq_out_ff[15:8] == dq_out_ff[7:0]
        && (dq_out_ff[7:1] == 7'h00 || dq_out_ff[7:1] == {7{dq_out_ff[0]}}))
        else $error("lane fill wrong");
    chk_exit_undef: assert property (
        // the pins let go one edge after the undefined flag rises
        mr1 && !cmd.addr[7] && wl_active_ff
        |=> dq_undef_ff ##1 (dq_undef_ff && dq_oe_n_ff) [*8])
        else $error("exit not undefined");
    chk_term_split: assert property (
        dqs_term_on_ff == ($past(odt) && wl_active_ff)
        && dq_term_on_ff == ($past(odt) && !wl_active_ff))
        else $error("termination split wrong");
    // main scenarios reached
    cover property (is_rd && mpr_active_ff);
    cover property (wl_active_ff && !dq_oe_n_ff && dq_out_ff[0]);
    cover property (mr1 && !cmd.addr[7] && wl_active_ff);
endmodule

// ===== dtml_train_tb_top.sv
// self-checking testbench for the training mode logic
`timescale 1ns/10ps
module dtml_train_tb_top import dtml_pkg::*; ;
    localparam int TMO_CYC = 5000;
    // chop, chop, full burst addresses with junk in the ignored bits
    localparam logic [38:0] RD_ADDRS = {13'h0ffc, 13'h0ff8, 13'h1ff8};
    logic clock;
    logic rst_n = 1'b0;
    logic [DTML_DQ_W-1:0] arr_rdata = 16'h0000;
    dtml_cmd_t cmd;
    logic odt, dqs_pin, ck_pin;
    logic [DTML_DQ_W-1:0] dq_out_ff;
    logic dq_oe_n_ff, dq_undef_ff, dqs_term_on_ff, dq_term_on_ff, wl_active_ff;
    logic mpr_active_ff, cmd_ready_ff, mrs_ready_ff, arr_rd_req_ff, auto_pre_req_ff;
    logic [2:0] arr_ba_ff;
    logic [9:0] arr_col_ff;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int i;
    logic [15:0] base;
    dtml_train uut (.clock, .rst_n, .cmd, .odt, .dqs_pin, .ck_pin, .arr_rdata,
        .dq_out_ff, .dq_oe_n_ff, .dq_undef_ff, .dqs_term_on_ff, .dq_term_on_ff,
        .wl_active_ff, .mpr_active_ff, .cmd_ready_ff, .mrs_ready_ff,
        .arr_rd_req_ff, .arr_ba_ff, .arr_col_ff, .auto_pre_req_ff);
    dtml_ctrl_model u_ctl (.clock, .cmd, .odt, .dqs_pin, .ck_pin);
    // 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // array data counts up each clock so every beat is traceable; hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        arr_rdata <= arr_rdata + 16'h0001;
        if (cyc == TMO_CYC) begin
            bad_count++;
            summarize();
        end
    end
    // one comparison, case equality so unknowns fail
    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // beats of a read taken at the edge just passed; kind 0 array, 1 pattern, 2 zero
    task automatic burst(input int n, input int kind);
        int j;
        logic [15:0] want;
        #1;
        base = arr_rdata;
        repeat (6) @(posedge clock);
        for (j = 0; j < n; j++) begin
            #1;
            want = (kind == 0) ? base + 16'(j + 4) : (kind == 1 && j[0]) ? 16'hffff : 16'h0000;
            chk({15'h0000, dq_oe_n_ff}, 16'h0000, "beat driven");
            chk(dq_out_ff, want, "beat data");
            @(posedge clock);
        end
        #1;
        chk({15'h0000, dq_oe_n_ff}, 16'h0001, "burst length");
    endtask
    task automatic done(input string name);
        $display("test %s finished, mismatches %0d", name, bad_count);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence: array read, pattern reads, leveling, reset in pattern mode
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk({11'h000, dq_oe_n_ff, cmd_ready_ff, mrs_ready_ff, wl_active_ff,
            mpr_active_ff}, 16'h001c, "reset values");
        done("reset");
        u_ctl.rd(3'h5, 13'h1567);
        #1;
        chk({arr_rd_req_ff, auto_pre_req_ff, 1'b0, arr_ba_ff, arr_col_ff},
            {3'b110, 3'h5, 10'h164}, "array read");
        burst(8, 0);
        done("array");
        u_ctl.mrs(DTML_BA_MR0, 13'h0001); // on-the-fly chop enabled
        idle(13);
        u_ctl.mrs(DTML_BA_MR3, 13'h0004);
        idle(13);
        chk({15'h0000, mpr_active_ff}, 16'h0001, "pattern mode on");
        for (i = 0; i < 3; i++) begin
            u_ctl.rd(3'(i + 2), RD_ADDRS[i*13 +: 13]);
            #1;
            chk({14'h0000, arr_rd_req_ff, auto_pre_req_ff}, 16'h0000, "no array");
            burst((i == 0) ? 8 : 4, 1);
        end
        u_ctl.mrs(DTML_BA_MR0, 13'h0002); // fixed chop
        idle(13);
        for (i = 1; i < 4; i++) begin
            u_ctl.mrs(DTML_BA_MR3, 13'h0004 | 13'(i));
            idle(13);
            u_ctl.rd(3'h0, 13'h1000);
            burst(4, 2);
        end
        done("pattern");
        u_ctl.mrs(DTML_BA_MR3, 13'h0003);
        idle(13);
        u_ctl.rd(3'h2, 13'h0008);
        #1;
        chk({13'h0000, mpr_active_ff, arr_rd_req_ff, auto_pre_req_ff}, 16'h0002, "array again");
        burst(4, 0);
        done("pattern exit");
        u_ctl.set_odt(1'b1);
        idle(2);
        #1;
        chk({14'h0000, dqs_term_on_ff, dq_term_on_ff}, 16'h0001, "data term normal");
        u_ctl.set_odt(1'b0);
        u_ctl.mrs(DTML_BA_MR1, 13'h0080);
        idle(13);
        chk({14'h0000, wl_active_ff, dq_undef_ff}, 16'h0003, "leveling armed");
        u_ctl.set_odt(1'b1);
        idle(2);
        #1;
        chk({14'h0000, dqs_term_on_ff, dq_term_on_ff}, 16'h0002, "strobe term only");
        u_ctl.strobe(1'b0);
        #1;
        chk({dq_oe_n_ff, dq_undef_ff, 14'h0000}, 16'h0000, "feedback driven");
        chk(dq_out_ff, 16'h0000, "feedback low");
        u_ctl.strobe(1'b1);
        #1;
        chk(dq_out_ff, 16'h0101, "feedback high");
        u_ctl.set_odt(1'b0);
        idle(2);
        u_ctl.mrs(DTML_BA_MR1, 13'h0000);
        idle(2);
        #1;
        chk({13'h0000, dq_undef_ff, dq_oe_n_ff, mrs_ready_ff}, 16'h0006, "exit undefined");
        idle(13);
        #1;
        chk({13'h0000, dq_undef_ff, wl_active_ff, cmd_ready_ff}, 16'h0001, "exit done");
        done("leveling");
        u_ctl.mrs(DTML_BA_MR3, 13'h0004);
        idle(13);
        rst_n <= 1'b0;
        idle(2);
        #1;
        chk({14'h0000, mpr_active_ff, cmd_ready_ff}, 16'h0001, "reset in pattern mode");
        idle(1);
        rst_n <= 1'b1;
        done("reset in pattern mode");
        summarize();
    end
endmodule
bind dtml_train dtml_train_chk #(.PRIME_ONLY(PRIME_ONLY)) u_chk (.clock, .rst_n, .cmd, .odt,
    .dq_out_ff, .dq_oe_n_ff, .dq_undef_ff, .dqs_term_on_ff, .dq_term_on_ff, .wl_active_ff,
    .mpr_active_ff, .cmd_ready_ff, .mrs_ready_ff, .arr_rd_req_ff, .auto_pre_req_ff);
